// ==== common/ufc_params.svh ====
// Constants of the flash command unit and of its calling core.
// Assumes it is included by bare name; definitions only.
`ifndef UFC_PARAMS_SVH
`define UFC_PARAMS_SVH

// ********************************
// Unit register offsets
// ********************************
`define UFC_OFF_ADDR_LO 8'ha8
`define UFC_OFF_ADDR_HI 8'ha9
`define UFC_OFF_RD_DATA 8'haa
`define UFC_OFF_WR_DATA 8'hab
`define UFC_OFF_TIMING 8'he1
`define UFC_OFF_KEY 8'he2
`define UFC_OFF_COUNT 8'hf1
`define UFC_REG_RESET 8'h00

// ********************************
// Call entry points and magic values
// ********************************
`define UFC_EP_PAGE_ERASE 8'h17
`define UFC_EP_MASS_ERASE 8'h1a
`define UFC_EP_READ_BYTE 8'h11
`define UFC_EP_BLOCK_READ 8'h26
`define UFC_EP_WRITE_BYTE 8'h14
`define UFC_EP_BLOCK_WRITE 8'h23
`define UFC_EP_EXIT 8'h62
`define UFC_EP_SERIAL_ISP 8'h00
`define UFC_KEY_VALUE 8'h98
`define UFC_MASS_CONFIRM 8'h55
`define UFC_BW_MAX 8'h10

// ********************************
// Timing counts
// ********************************
`define UFC_CLK_PER_INSTR 3'h5
`define UFC_KEY_WINDOW 3'h6

// ********************************
// Core-side software register offsets
// ********************************
`define UFC_H_TGT 4'h0
`define UFC_H_WDATA 4'h1
`define UFC_H_RDREQ 4'h2
`define UFC_H_RDATA 4'h3
`define UFC_H_ACC 4'h4
`define UFC_H_XPTR 4'h5
`define UFC_H_CALL 4'h6
`define UFC_H_STATUS 4'h7
`define UFC_H_RAMADR 4'h8
`define UFC_H_RAMDAT 4'h9

`endif

// ==== common/ufc_pkg.sv ====
// Types of the flash command unit, also used by the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package ufc_pkg;

  // Flash array operation
  typedef enum logic [1:0] {
    FL_READ,
    FL_WRITE,
    FL_PAGE_ERASE,
    FL_MASS_ERASE
  } ufc_fl_op_t;

  // Unit sequencer state
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_FLASH,
    ST_BR_FL,
    ST_BR_PUSH,
    ST_BW_REQ,
    ST_BW_WAIT,
    ST_BW_FL,
    ST_FIN,
    ST_ISP,
    ST_RST
  } ufc_state_t;

endpackage

// ==== common/ufc_if.sv ====
// Link between the calling core and the flash command unit.
// Assumes both ends run on one shared clock.
`timescale 1ns/10ps
interface ufc_if;
  // Register port, core to unit
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  // Boot-ROM call and its arguments
  logic call;
  logic [7:0] entry;
  logic [7:0] acc;
  logic [7:0] xptr;
  logic busy;
  logic done;
  logic irq_block;
  // RAM request stream, unit to core
  logic ram_valid;
  logic ram_ready;
  logic ram_we;
  logic [7:0] ram_addr;
  logic [7:0] ram_wdata;
  logic ram_rvalid;
  logic [7:0] ram_rdata;

  modport dev (
    input reg_addr, reg_wdata, reg_wr, reg_rd, call, entry, acc, xptr,
    input ram_ready, ram_rvalid, ram_rdata,
    output reg_rdata, busy, done, irq_block, ram_valid, ram_we, ram_addr, ram_wdata
  );
  modport core (
    output reg_addr, reg_wdata, reg_wr, reg_rd, call, entry, acc, xptr,
    output ram_ready, ram_rvalid, ram_rdata,
    input reg_rdata, busy, done, irq_block, ram_valid, ram_we, ram_addr, ram_wdata
  );
endinterface

// ==== verilog/ufc_unit.sv ====
// Flash command unit: register file, keyed call sequencer and RAM stream.
// Assumes a flash array port that answers each request with a done pulse,
// and a core that serves RAM requests and reads one cycle after acceptance.
//
// Functional notes
// - Entry 0x17 erases page at address registers
// - Entry 0x1A mass erase needs accumulator 0x55
// - Entry 0x11 reads byte into read register
// - Entry 0x26 copies n flash bytes to RAM
// - Entry 0x14 writes write-data byte to flash
// - Entry 0x23 writes up to 16 RAM bytes
// - Caller keeps block writes inside 64 bytes
// - Entry 0x62 resets the whole device
// - Entry 0x00 holds serial mode until exit
// - Call valid only within 6 instruction cycles of key
// - Caller writes key 0x98 before each call
// - Caller loads write timing before write/erase
// - Flash address from registers 0xA9 and 0xA8
// - Interrupts blocked while a routine runs
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
`include "ufc_params.svh"

// ********************************
// Two-entry buffer
// ********************************
module ufc_buf #(
  parameter int W = 17
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Filling side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Draining side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data,
  output logic o_empty
);
  logic [W-1:0] mem_q [0:1];
  logic wp_q;
  logic rp_q;
  logic [1:0] cnt_q;
  wire logic push = i_valid && o_ready;
  wire logic pop = o_valid && i_ready;

  // Handshake decode
  assign o_ready = (cnt_q != 2'h2);
  assign o_valid = (cnt_q != 2'h0);
  assign o_empty = (cnt_q == 2'h0);
  assign o_data = mem_q[rp_q];

  // Storage, written only on push
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wp_q] <= i_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wp_q <= ~wp_q;
      if (pop) rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ********************************
// Command unit
// ********************************
module ufc_unit (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Core link
  ufc_if.dev bus,
  // Flash array port
  output logic o_fl_req,
  output ufc_pkg::ufc_fl_op_t o_fl_op,
  output logic [15:0] o_fl_addr,
  output logic [7:0] o_fl_wdata,
  output logic [7:0] o_fl_timing,
  input wire logic i_fl_done,
  input wire logic [7:0] i_fl_rdata,
  // Serial mode and device reset
  input wire logic i_isp_exit,
  output logic o_isp_mode,
  output logic o_dev_reset
);
  ufc_pkg::ufc_state_t state_q;
  ufc_pkg::ufc_fl_op_t op_q;
  logic [7:0] addr_lo_q, addr_hi_q, wr_data_q, timing_q, count_q, rd_data_q;
  logic [7:0] rdata_q, dat_q, x_q, cnt_q;
  logic [15:0] a_q;
  logic [2:0] div_q, key_cnt_q;
  logic exit_s1_q, exit_s2_q, exit_s3_q;

  // Register decode
  wire logic hit_lo = bus.reg_addr == `UFC_OFF_ADDR_LO;
  wire logic hit_hi = bus.reg_addr == `UFC_OFF_ADDR_HI;
  wire logic hit_rd = bus.reg_addr == `UFC_OFF_RD_DATA;
  wire logic hit_wd = bus.reg_addr == `UFC_OFF_WR_DATA;
  wire logic hit_tm = bus.reg_addr == `UFC_OFF_TIMING;
  wire logic hit_key = bus.reg_addr == `UFC_OFF_KEY;
  wire logic hit_cnt = bus.reg_addr == `UFC_OFF_COUNT;
  wire logic [7:0] rd_mux = hit_lo ? addr_lo_q : hit_hi ? addr_hi_q :
                            hit_rd ? rd_data_q : hit_wd ? wr_data_q :
                            hit_tm ? timing_q : hit_cnt ? count_q : 8'h00;

  // Call qualification; the key is spent by any call, good or not
  wire logic tick = (div_q == `UFC_CLK_PER_INSTR - 3'h1);
  wire logic idle = (state_q == ufc_pkg::ST_IDLE);
  wire logic call_ok = bus.call && idle && (key_cnt_q != 3'h0);
  wire logic [7:0] bw_n = (count_q > `UFC_BW_MAX) ? `UFC_BW_MAX : count_q;
  wire logic last = (cnt_q == 8'h01);
  wire logic exit_seen = exit_s2_q && exit_s3_q;

  // RAM stream through the buffer, so a stalled core loses no word
  wire logic br_push = (state_q == ufc_pkg::ST_BR_PUSH);
  wire logic push_v = br_push || (state_q == ufc_pkg::ST_BW_REQ);
  wire logic push_rdy;
  wire logic buf_empty;
  wire logic [16:0] push_d = {br_push, x_q, dat_q};
  wire logic [16:0] pop_d;
  ufc_buf #(.W(17)) u_buf (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_valid(push_v),
    .o_ready(push_rdy),
    .i_data(push_d),
    .o_valid(bus.ram_valid),
    .i_ready(bus.ram_ready),
    .o_data(pop_d),
    .o_empty(buf_empty)
  );
  assign bus.ram_we = pop_d[16];
  assign bus.ram_addr = pop_d[15:8];
  assign bus.ram_wdata = pop_d[7:0];

  // Outputs
  assign o_fl_req = (state_q == ufc_pkg::ST_FLASH) || (state_q == ufc_pkg::ST_BR_FL) ||
                    (state_q == ufc_pkg::ST_BW_FL);
  assign o_fl_op = op_q;
  assign o_fl_addr = a_q;
  assign o_fl_wdata = dat_q;
  assign o_fl_timing = timing_q;
  assign o_isp_mode = (state_q == ufc_pkg::ST_ISP);
  assign o_dev_reset = (state_q == ufc_pkg::ST_RST);
  assign bus.busy = !idle;
  assign bus.irq_block = !idle;
  assign bus.done = (state_q == ufc_pkg::ST_FIN) && buf_empty;
  assign bus.reg_rdata = rdata_q;

  // Parameter registers; read data stands one cycle only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_lo_q <= `UFC_REG_RESET;
      addr_hi_q <= `UFC_REG_RESET;
      wr_data_q <= `UFC_REG_RESET;
      timing_q <= `UFC_REG_RESET;
      count_q <= `UFC_REG_RESET;
      rdata_q <= 8'h00;
    end else begin
      if (bus.reg_wr && hit_lo) addr_lo_q <= bus.reg_wdata;
      if (bus.reg_wr && hit_hi) addr_hi_q <= bus.reg_wdata;
      if (bus.reg_wr && hit_wd) wr_data_q <= bus.reg_wdata;
      if (bus.reg_wr && hit_tm) timing_q <= bus.reg_wdata;
      if (bus.reg_wr && hit_cnt) count_q <= bus.reg_wdata;
      rdata_q <= bus.reg_rd ? rd_mux : 8'h00;
    end
  end

  // Instruction-cycle divider and key window; a fresh key write wins
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 3'h0;
      key_cnt_q <= 3'h0;
    end else begin
      div_q <= tick ? 3'h0 : div_q + 3'h1;
      if (bus.reg_wr && hit_key) begin
        key_cnt_q <= (bus.reg_wdata == `UFC_KEY_VALUE) ? `UFC_KEY_WINDOW : 3'h0;
      end else if (bus.call) begin
        key_cnt_q <= 3'h0;
      end else if (tick && key_cnt_q != 3'h0) begin
        key_cnt_q <= key_cnt_q - 3'h1;
      end
    end
  end

  // Exit pin synchroniser; only the last two stages are compared
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      exit_s1_q <= 1'b0;
      exit_s2_q <= 1'b0;
      exit_s3_q <= 1'b0;
    end else begin
      exit_s1_q <= i_isp_exit;
      exit_s2_q <= exit_s1_q;
      exit_s3_q <= exit_s2_q;
    end
  end

  // Sequencer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= ufc_pkg::ST_IDLE;
      op_q <= ufc_pkg::FL_READ;
      a_q <= 16'h0000;
      x_q <= 8'h00;
      cnt_q <= 8'h00;
      dat_q <= 8'h00;
      rd_data_q <= `UFC_REG_RESET;
    end else begin
      case (state_q)
        ufc_pkg::ST_IDLE: begin
          if (call_ok) begin
            a_q <= {addr_hi_q, addr_lo_q};
            x_q <= bus.xptr;
            dat_q <= wr_data_q;
            case (bus.entry)
              `UFC_EP_PAGE_ERASE: begin
                op_q <= ufc_pkg::FL_PAGE_ERASE;
                state_q <= ufc_pkg::ST_FLASH;
              end
              `UFC_EP_MASS_ERASE: begin
                op_q <= ufc_pkg::FL_MASS_ERASE;
                state_q <= (bus.acc == `UFC_MASS_CONFIRM) ? ufc_pkg::ST_FLASH :
                           ufc_pkg::ST_FIN;
              end
              `UFC_EP_READ_BYTE: begin
                op_q <= ufc_pkg::FL_READ;
                state_q <= ufc_pkg::ST_FLASH;
              end
              `UFC_EP_WRITE_BYTE: begin
                op_q <= ufc_pkg::FL_WRITE;
                state_q <= ufc_pkg::ST_FLASH;
              end
              `UFC_EP_BLOCK_READ: begin
                op_q <= ufc_pkg::FL_READ;
                cnt_q <= count_q;
                state_q <= (count_q == 8'h00) ? ufc_pkg::ST_FIN : ufc_pkg::ST_BR_FL;
              end
              `UFC_EP_BLOCK_WRITE: begin
                op_q <= ufc_pkg::FL_WRITE;
                cnt_q <= bw_n;
                state_q <= (bw_n == 8'h00) ? ufc_pkg::ST_FIN : ufc_pkg::ST_BW_REQ;
              end
              `UFC_EP_EXIT: state_q <= ufc_pkg::ST_RST;
              `UFC_EP_SERIAL_ISP: state_q <= ufc_pkg::ST_ISP;
              default: state_q <= ufc_pkg::ST_IDLE;
            endcase
          end
        end
        ufc_pkg::ST_FLASH: begin
          if (i_fl_done) begin
            if (op_q == ufc_pkg::FL_READ) rd_data_q <= i_fl_rdata;
            state_q <= ufc_pkg::ST_FIN;
          end
        end
        ufc_pkg::ST_BR_FL: begin
          if (i_fl_done) begin
            dat_q <= i_fl_rdata;
            state_q <= ufc_pkg::ST_BR_PUSH;
          end
        end
        ufc_pkg::ST_BR_PUSH: begin
          if (push_rdy) begin
            a_q <= a_q + 16'h0001;
            x_q <= x_q + 8'h01;
            cnt_q <= cnt_q - 8'h01;
            state_q <= last ? ufc_pkg::ST_FIN : ufc_pkg::ST_BR_FL;
          end
        end
        ufc_pkg::ST_BW_REQ: begin
          if (push_rdy) state_q <= ufc_pkg::ST_BW_WAIT;
        end
        ufc_pkg::ST_BW_WAIT: begin
          if (bus.ram_rvalid) begin
            dat_q <= bus.ram_rdata;
            state_q <= ufc_pkg::ST_BW_FL;
          end
        end
        ufc_pkg::ST_BW_FL: begin
          if (i_fl_done) begin
            a_q <= a_q + 16'h0001;
            x_q <= x_q + 8'h01;
            cnt_q <= cnt_q - 8'h01;
            state_q <= last ? ufc_pkg::ST_FIN : ufc_pkg::ST_BW_REQ;
          end
        end
        ufc_pkg::ST_FIN: begin
          // Done only once every RAM write has left the buffer
          if (buf_empty) state_q <= ufc_pkg::ST_IDLE;
        end
        ufc_pkg::ST_ISP: begin
          if (exit_seen) state_q <= ufc_pkg::ST_RST;
        end
        ufc_pkg::ST_RST: state_q <= ufc_pkg::ST_IDLE;
        default: state_q <= ufc_pkg::ST_IDLE;
      endcase
    end
  end
endmodule

// ==== verilog/ufc_core.sv ====
// Calling core end: software registers, keyed call issue and RAM.
// Assumes the command unit on the other side of the link, same clock.
`timescale 1ns/10ps
`include "ufc_params.svh"
module ufc_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Unit link
  ufc_if.core bus,
  // Software port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Core side
  input wire logic i_ram_hold,
  output logic o_irq_block
);
  logic [7:0] ram_q [0:255];
  logic [7:0] tgt_q, acc_q, xptr_q, drd_q, ramadr_q, rdata_q, entry_q;
  logic [7:0] baddr_q, bwdata_q, ram_rdata_q;
  logic bwr_q, brd_q, rd_wait_q, call_pend_q, call_q, done_q, ram_rvalid_q;

  // Software decode
  wire logic w_wd = i_wr && i_addr == `UFC_H_WDATA;
  wire logic w_rq = i_wr && i_addr == `UFC_H_RDREQ;
  wire logic w_call = i_wr && i_addr == `UFC_H_CALL;
  wire logic w_ram = i_wr && i_addr == `UFC_H_RAMDAT;
  wire logic r_stat = i_rd && i_addr == `UFC_H_STATUS;
  wire logic [7:0] status = {5'h00, bus.irq_block, done_q, bus.busy || call_pend_q};
  wire logic [7:0] rd_mux = (i_addr == `UFC_H_TGT) ? tgt_q :
                            (i_addr == `UFC_H_RDATA) ? drd_q :
                            (i_addr == `UFC_H_ACC) ? acc_q :
                            (i_addr == `UFC_H_XPTR) ? xptr_q :
                            (i_addr == `UFC_H_STATUS) ? status :
                            (i_addr == `UFC_H_RAMADR) ? ramadr_q :
                            (i_addr == `UFC_H_RAMDAT) ? ram_q[ramadr_q] : 8'h00;

  // RAM service; a software RAM write stalls the unit for that cycle
  wire logic ram_take = bus.ram_valid && bus.ram_ready;
  assign bus.ram_ready = !i_ram_hold && !w_ram;
  assign bus.ram_rvalid = ram_rvalid_q;
  assign bus.ram_rdata = ram_rdata_q;

  // Link outputs
  assign bus.reg_addr = baddr_q;
  assign bus.reg_wdata = bwdata_q;
  assign bus.reg_wr = bwr_q;
  assign bus.reg_rd = brd_q;
  assign bus.call = call_q;
  assign bus.entry = entry_q;
  assign bus.acc = acc_q;
  assign bus.xptr = xptr_q;
  assign o_irq_block = bus.irq_block;
  assign o_rdata = rdata_q;

  // RAM array, no reset needed
  always_ff @(posedge i_clk) begin
    if (ram_take && bus.ram_we) begin
      ram_q[bus.ram_addr] <= bus.ram_wdata;
    end else if (w_ram) begin
      ram_q[ramadr_q] <= i_wdata;
    end
    ram_rdata_q <= ram_q[bus.ram_addr];
  end

  // Software registers and sticky done; the set beats the read clear
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tgt_q <= 8'h00;
      acc_q <= 8'h00;
      xptr_q <= 8'h00;
      ramadr_q <= 8'h00;
      drd_q <= 8'h00;
      rdata_q <= 8'h00;
      done_q <= 1'b0;
      ram_rvalid_q <= 1'b0;
      rd_wait_q <= 1'b0;
    end else begin
      if (i_wr && i_addr == `UFC_H_TGT) tgt_q <= i_wdata;
      if (i_wr && i_addr == `UFC_H_ACC) acc_q <= i_wdata;
      if (i_wr && i_addr == `UFC_H_XPTR) xptr_q <= i_wdata;
      if (i_wr && i_addr == `UFC_H_RAMADR) ramadr_q <= i_wdata;
      rd_wait_q <= brd_q;
      if (rd_wait_q) drd_q <= bus.reg_rdata;
      rdata_q <= i_rd ? rd_mux : 8'h00;
      done_q <= bus.done || (done_q && !r_stat);
      ram_rvalid_q <= ram_take && !bus.ram_we;
    end
  end

  // Link issue: key write, then the call in the very next cycle
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      baddr_q <= 8'h00;
      bwdata_q <= 8'h00;
      bwr_q <= 1'b0;
      brd_q <= 1'b0;
      call_pend_q <= 1'b0;
      call_q <= 1'b0;
      entry_q <= 8'h00;
    end else begin
      bwr_q <= w_wd || w_call;
      brd_q <= w_rq;
      if (w_call) begin
        baddr_q <= `UFC_OFF_KEY;
        bwdata_q <= `UFC_KEY_VALUE;
        entry_q <= i_wdata;
      end else if (w_wd || w_rq) begin
        baddr_q <= tgt_q;
        bwdata_q <= i_wdata;
      end
      call_q <= call_pend_q;
      call_pend_q <= w_call;
    end
  end
endmodule

// ==== verification/ufc_link_props.sv ====
// Checker for the link between the calling core and the command unit.
// Assumes one shared clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`include "ufc_params.svh"
module ufc_link_props (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Register port and call
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic call,
  input wire logic [7:0] entry,
  input wire logic busy,
  input wire logic done,
  input wire logic irq_block,
  // RAM stream
  input wire logic ram_valid,
  input wire logic ram_ready,
  input wire logic ram_we,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  input wire logic ram_rvalid
);
  // ********************************
  // Key age tracking
  // ********************************
  logic [7:0] kage_q;
  logic [7:0] kage_d;
  logic key_wr;
  logic op_ep;
  // Age saturates at ff, so a stale key never looks fresh again
  assign key_wr = reg_wr && (reg_addr == `UFC_OFF_KEY);
  assign op_ep = entry inside {`UFC_EP_READ_BYTE, `UFC_EP_WRITE_BYTE, `UFC_EP_PAGE_ERASE,
                               `UFC_EP_MASS_ERASE, `UFC_EP_BLOCK_READ, `UFC_EP_BLOCK_WRITE};
  assign kage_d = key_wr ? ((reg_wdata == `UFC_KEY_VALUE) ? 8'h00 : 8'hff) :
                  (call || kage_q == 8'hff) ? 8'hff : kage_q + 8'h01;
  // Age register
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) kage_q <= 8'hff;
    else kage_q <= kage_d;
  end

  // ********************************
  // Assertions
  // ********************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  chk_keyed_call: assert property (
    call && !busy && op_ep && kage_q < 8'h14 |=> busy) else $error("Keyed call not started");
  chk_stale_call: assert property (
    call && !busy && kage_q > 8'h1f |=> !busy) else $error("Unkeyed call started");
  chk_irq_follows: assert property (
    irq_block == busy) else $error("Interrupt block differs from busy");
  chk_done_pulse: assert property (
    done |=> !done) else $error("Done longer than one cycle");
  chk_done_ends: assert property (
    done |-> busy ##1 !busy) else $error("Done not at end of routine");
  chk_rdata_quiet: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("Read data without read");
  chk_stall_holds: assert property (
    ram_valid && !ram_ready |=> ram_valid && $stable(ram_addr) && $stable(ram_wdata)
    && $stable(ram_we)) else $error("Stalled RAM request changed");
  chk_ram_answer: assert property (
    ram_valid && ram_ready && !ram_we |=> ram_rvalid) else $error("RAM read not answered");
  chk_idle_quiet: assert property (
    !busy |-> !ram_valid) else $error("RAM request while idle");
endmodule

// ==== verification/tb_top.sv ====
// Bench: software port tasks drive the core, which calls the unit over the link.
// Assumes the flash array modelled here and one 25 MHz clock.
`timescale 1ns/10ps
`include "ufc_params.svh"
module tb_top;
  logic i_clk;
  logic i_arst_n;
  logic [3:0] sw_addr;
  logic [7:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [7:0] sw_rdata;
  logic ram_hold;
  logic irq_blk;
  logic fl_req;
  ufc_pkg::ufc_fl_op_t fl_op;
  ufc_pkg::ufc_fl_op_t last_op;
  logic [15:0] fl_addr;
  logic [15:0] last_addr;
  logic [7:0] fl_wdata;
  logic [7:0] fl_timing;
  logic fl_done;
  logic [7:0] fl_rdata;
  logic isp_exit;
  logic isp_mode;
  logic dev_reset;
  logic [7:0] fmem [0:65535];
  logic [7:0] v;
  int err_count;
  int checked;
  int fl_reqs;
  int resets;
  int n;

  // ********************************
  // Both ends and the checker
  // ********************************
  ufc_if u_ufc_if ();
  ufc_core u_ufc_core (.i_clk, .i_arst_n, .bus(u_ufc_if), .i_addr(sw_addr),
    .i_wdata(sw_wdata), .i_wr(sw_wr), .i_rd(sw_rd), .o_rdata(sw_rdata),
    .i_ram_hold(ram_hold), .o_irq_block(irq_blk));
  ufc_unit u_ufc_unit (.i_clk, .i_arst_n, .bus(u_ufc_if), .o_fl_req(fl_req),
    .o_fl_op(fl_op), .o_fl_addr(fl_addr), .o_fl_wdata(fl_wdata), .o_fl_timing(fl_timing),
    .i_fl_done(fl_done), .i_fl_rdata(fl_rdata), .i_isp_exit(isp_exit),
    .o_isp_mode(isp_mode), .o_dev_reset(dev_reset));
  ufc_link_props u_ufc_link_props (.i_clk, .i_arst_n, .reg_addr(u_ufc_if.reg_addr),
    .reg_wdata(u_ufc_if.reg_wdata), .reg_wr(u_ufc_if.reg_wr), .reg_rd(u_ufc_if.reg_rd),
    .reg_rdata(u_ufc_if.reg_rdata), .call(u_ufc_if.call), .entry(u_ufc_if.entry),
    .busy(u_ufc_if.busy), .done(u_ufc_if.done), .irq_block(u_ufc_if.irq_block),
    .ram_valid(u_ufc_if.ram_valid), .ram_ready(u_ufc_if.ram_ready),
    .ram_we(u_ufc_if.ram_we), .ram_addr(u_ufc_if.ram_addr),
    .ram_wdata(u_ufc_if.ram_wdata), .ram_rvalid(u_ufc_if.ram_rvalid));

  // Clock at 25 MHz
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Flash array: each request answered by a done pulse one cycle later
  always @(posedge i_clk) begin
    fl_done <= fl_req && !fl_done;
    if (fl_req && !fl_done) begin
      fl_rdata <= fmem[fl_addr];
      fl_reqs <= fl_reqs + 1;
      last_op <= fl_op;
      last_addr <= fl_addr;
      if (fl_op == ufc_pkg::FL_WRITE) fmem[fl_addr] <= fl_wdata;
    end
    if (dev_reset) resets <= resets + 1;
  end

  // ********************************
  // Tasks
  // ********************************
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A gap cycle between strobes keeps each strobe assigned once per step
  task automatic sw_w(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge i_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_r(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge i_clk);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic uw(input logic [7:0] r, input logic [7:0] d);
    sw_w(`UFC_H_TGT, r);
    sw_w(`UFC_H_WDATA, d);
  endtask
  task automatic ur(input logic [7:0] r, output logic [7:0] d);
    sw_w(`UFC_H_TGT, r);
    sw_w(`UFC_H_RDREQ, 8'h00);
    repeat (2) @(posedge i_clk);
    sw_r(`UFC_H_RDATA, d);
  endtask
  // Core writes the key itself, then calls
  task automatic go(input logic [7:0] e, input logic [7:0] a, input logic [7:0] x);
    sw_w(`UFC_H_ACC, a);
    sw_w(`UFC_H_XPTR, x);
    sw_w(`UFC_H_CALL, e);
  endtask
  task automatic idle;
    int k = 0;
    repeat (4) @(posedge i_clk);
    while (u_ufc_if.busy !== 1'b0 && k < 3000) begin
      @(posedge i_clk);
      k++;
    end
    if (k == 3000) begin
      err_count++;
      complete_run;
    end
  endtask

  // ********************************
  // Main sequence
  // ********************************
  initial begin
    i_arst_n = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    ram_hold = 1'b0;
    fl_done = 1'b0;
    fl_rdata = 8'h00;
    isp_exit = 1'b0;
    fmem[16'h1234] = 8'h5a;
    fmem[16'h1235] = 8'ha5;
    fmem[16'h1236] = 8'h3c;
    fmem[16'h2010] = 8'hff;
    repeat (20) @(posedge i_clk);
    i_arst_n <= 1'b1;
    // Register file, key reads zero, unmapped place reads zero
    uw(`UFC_OFF_ADDR_HI, 8'h12);
    uw(`UFC_OFF_ADDR_LO, 8'h34);
    uw(`UFC_OFF_TIMING, 8'h2b);
    ur(`UFC_OFF_ADDR_HI, v);
    check("addr_high", v, 8'h12);
    ur(`UFC_OFF_KEY, v);
    check("key_read", v, 8'h00);
    ur(8'hb0, v);
    check("unmapped", v, 8'h00);
    check("timing", fl_timing, 8'h2b);
    // Read byte, then write byte and page erase
    go(`UFC_EP_READ_BYTE, 8'h00, 8'h00);
    idle;
    ur(`UFC_OFF_RD_DATA, v);
    check("read_byte", v, 8'h5a);
    check("read_addr", last_addr, 16'h1234);
    uw(`UFC_OFF_WR_DATA, 8'hc3);
    uw(`UFC_OFF_ADDR_LO, 8'h40);
    go(`UFC_EP_WRITE_BYTE, 8'h00, 8'h00);
    idle;
    check("write_byte", fmem[16'h1240], 8'hc3);
    go(`UFC_EP_PAGE_ERASE, 8'h00, 8'h00);
    idle;
    check("page_op", last_op, ufc_pkg::FL_PAGE_ERASE);
    check("page_addr", last_addr, 16'h1240);
    // Mass erase needs the confirmation value
    n = fl_reqs;
    go(`UFC_EP_MASS_ERASE, 8'h54, 8'h00);
    idle;
    check("mass_refused", fl_reqs, n);
    // Refused mass erase still ends with a done, kept sticky until read
    sw_r(`UFC_H_STATUS, v);
    check("done_sticky", v, 8'h02);
    sw_r(`UFC_H_STATUS, v);
    check("done_cleared", v, 8'h00);
    go(`UFC_EP_MASS_ERASE, `UFC_MASS_CONFIRM, 8'h00);
    idle;
    check("mass_op", last_op, ufc_pkg::FL_MASS_ERASE);
    // Block read with the RAM side stalled and a call made while busy
    uw(`UFC_OFF_ADDR_LO, 8'h34);
    uw(`UFC_OFF_COUNT, 8'h03);
    ram_hold <= 1'b1;
    go(`UFC_EP_BLOCK_READ, 8'h00, 8'h40);
    repeat (20) @(posedge i_clk);
    check("irq_block", irq_blk, 1'b1);
    go(`UFC_EP_WRITE_BYTE, 8'h00, 8'h00);
    ram_hold <= 1'b0;
    idle;
    check("busy_call", fmem[16'h1234], 8'h5a);
    ur(`UFC_OFF_ADDR_LO, v);
    check("addr_kept", v, 8'h34);
    for (int i = 0; i < 3; i++) begin
      sw_w(`UFC_H_RAMADR, 8'h40 + 8'(i));
      sw_r(`UFC_H_RAMDAT, v);
      check("block_read", v, (i == 0) ? 8'h5a : (i == 1) ? 8'ha5 : 8'h3c);
    end
    // Block write of the largest count, then of none
    for (int i = 0; i < 16; i++) begin
      sw_w(`UFC_H_RAMADR, 8'h80 + 8'(i));
      sw_w(`UFC_H_RAMDAT, 8'h10 + 8'(i));
    end
    uw(`UFC_OFF_ADDR_HI, 8'h20);
    uw(`UFC_OFF_ADDR_LO, 8'h00);
    uw(`UFC_OFF_COUNT, 8'h10);
    go(`UFC_EP_BLOCK_WRITE, 8'h00, 8'h80);
    idle;
    for (int i = 0; i < 17; i++) begin
      check("block_write", fmem[16'h2000 + 16'(i)], (i < 16) ? 8'h10 + 8'(i) : 8'hff);
    end
    n = fl_reqs;
    uw(`UFC_OFF_COUNT, 8'h00);
    go(`UFC_EP_BLOCK_WRITE, 8'h00, 8'h80);
    idle;
    check("count_zero", fl_reqs, n);
    // Serial mode holds until its exit, which resets the device
    go(`UFC_EP_SERIAL_ISP, 8'h00, 8'h00);
    repeat (30) @(posedge i_clk);
    check("isp_mode", isp_mode, 1'b1);
    isp_exit <= 1'b1;
    for (int i = 0; i < 20 && resets == 0; i++) @(posedge i_clk);
    check("isp_reset", resets, 1);
    isp_exit <= 1'b0;
    idle;
    check("isp_left", isp_mode, 1'b0);
    // Exit resets the device
    go(`UFC_EP_EXIT, 8'h00, 8'h00);
    repeat (4) @(posedge i_clk);
    check("exit_reset", resets, 2);
    idle;
    complete_run;
  end
endmodule
